// ### etr_pkg.sv
package etr_pkg;
  // Capture modes.
  typedef enum logic [1:0] {
    ETR_MODE_FREE = 2'h0,
    ETR_MODE_TRIG = 2'h1
  } etr_mode_t;

  // Sequencer states, Gray coded along idle, arm, expose, delay, readout.
  typedef enum logic [2:0] {
    ETR_ST_IDLE = 3'h0,
    ETR_ST_ARM = 3'h1,
    ETR_ST_EXPOSE = 3'h3,
    ETR_ST_DELAY = 3'h2,
    ETR_ST_READ = 3'h6,
    ETR_ST_GAP = 3'h7
  } etr_state_t;

  localparam int ETR_CLK_MHZ_X10 = 666;
  localparam int ETR_STEP_NS = 15;
  // Short fixed delay before exposure when no readout is running.
  localparam int ETR_START_DLY_NS = 150;
  localparam logic [7:0] ETR_START_DLY_CYC =
    8'((ETR_START_DLY_NS + ETR_STEP_NS - 1) / ETR_STEP_NS);
  localparam int ETR_PIX_IN_W = 12;
  localparam int ETR_PIX_OUT_W = 8;
  localparam int ETR_DUR_W = 24;
  localparam int ETR_CNT_W = 16;
  localparam int ETR_LUT_DEPTH = 4096;
  localparam int ETR_MAP_DEPTH = 64;
  localparam int ETR_MAP_AW = 6;
  localparam logic [15:0] ETR_LINE_GAP_CYC = 16'h0008;
  localparam logic [7:0] ETR_TEMP_LIMIT_RST = 8'h50;
  localparam logic [23:0] ETR_BLINK_HALF_CYC = 24'h7F0000;
endpackage : etr_pkg

// ### etr_skid_buf.sv
`timescale 1ns/10ps
// Two-entry buffer; a stalled receiver loses no word.
module etr_skid_buf #(
  parameter int W = 10
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  logic [W-1:0] mem_reg [0:1];
  logic wr_ptr_reg;
  logic rd_ptr_reg;
  logic [1:0] cnt_reg;
  logic do_wr;
  logic do_rd;

  // Handshakes on each side.
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;
  assign in_ready = (cnt_reg != 2'h2);
  assign out_valid = (cnt_reg != 2'h0);
  assign out_data = mem_reg[rd_ptr_reg];

  // Storage is written without reset; only occupancy needs a known value.
  always_ff @(posedge core_clk) begin
    if (do_wr) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers and fill level.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      cnt_reg <= 2'h0;
    end else begin
      if (do_wr) begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (do_rd) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      cnt_reg <= cnt_reg + {1'b0, do_wr} - {1'b0, do_rd};
    end
  end
endmodule : etr_skid_buf

// ### etr_ctrl.sv
`timescale 1ns/10ps
module etr_ctrl
  import etr_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic mode_trig,
  input wire logic run_en,
  input wire logic [ETR_DUR_W-1:0] exposure_cycles,
  input wire logic [ETR_DUR_W-1:0] readout_delay_cycles,
  input wire logic trigger_in,
  input wire logic sw_trigger,
  input wire logic [ETR_CNT_W-1:0] line_cycles,
  input wire logic [ETR_CNT_W-1:0] frame_lines,
  input wire logic aoi_en,
  input wire logic [ETR_CNT_W-1:0] aoi_first_line,
  input wire logic [ETR_CNT_W-1:0] aoi_lines,
  input wire logic [ETR_PIX_IN_W-1:0] sensor_pixel,
  input wire logic lut_en,
  input wire logic lut_wr_en,
  input wire logic [ETR_PIX_IN_W-1:0] lut_wr_addr,
  input wire logic [ETR_PIX_OUT_W-1:0] lut_wr_data,
  input wire logic dpc_en,
  input wire logic dpc_custom_sel,
  input wire logic map_wr_en,
  input wire logic map_wr_custom,
  input wire logic [ETR_MAP_AW-1:0] map_wr_addr,
  input wire logic [31:0] map_wr_data,
  input wire logic [7:0] temp_sample,
  input wire logic [7:0] temp_limit,
  input wire logic pix_ready,
  output logic exposing,
  output logic line_valid_strobe,
  output logic frame_valid_strobe,
  output logic [ETR_PIX_OUT_W-1:0] pix_data,
  output logic pix_valid,
  output logic pix_line_valid,
  output logic [7:0] temp_value,
  output logic temp_high,
  output logic red_led
);
  etr_state_t state_reg;
  logic trig_s1_reg;
  logic trig_s2_reg;
  logic trig_d_reg;
  logic sw_d_reg;
  logic trig_rise;
  logic trig_fall;
  logic sw_rise;
  logic [ETR_DUR_W-1:0] cnt_reg;
  logic [ETR_CNT_W-1:0] col_reg;
  logic [ETR_CNT_W-1:0] line_reg;
  logic [ETR_CNT_W-1:0] lines_to_read;
  logic [ETR_CNT_W-1:0] first_line;
  logic sync_line_wait_reg;
  logic sw_pending_reg;
  logic lv_fall;
  logic buf_in_ready;
  logic [ETR_PIX_OUT_W-1:0] lut_mem [0:ETR_LUT_DEPTH-1];
  logic [31:0] map_factory [0:ETR_MAP_DEPTH-1];
  logic [31:0] map_custom [0:ETR_MAP_DEPTH-1];
  logic [ETR_MAP_DEPTH-1:0] map_factory_vld_reg;
  logic [ETR_MAP_DEPTH-1:0] map_custom_vld_reg;
  logic [ETR_PIX_OUT_W-1:0] mapped_pix;
  logic [ETR_PIX_OUT_W-1:0] prev_pix_reg;
  logic defect_hit;
  logic [ETR_PIX_OUT_W-1:0] corr_pix;
  logic [ETR_PIX_OUT_W+1:0] buf_in_data;
  logic [ETR_PIX_OUT_W+1:0] buf_out_data;
  logic buf_out_valid;
  logic [23:0] blink_cnt_reg;
  logic stall;

  // Map entry layout: bit 31 valid, bits 30..16 line, bits 15..0 column.
  function automatic logic map_match(input logic [31:0] ent,
                                     input logic [ETR_CNT_W-1:0] ln,
                                     input logic [ETR_CNT_W-1:0] cl);
    map_match = ent[31] && (ent[30:16] == ln[14:0]) && (ent[15:0] == cl);
  endfunction : map_match

  // Two flip-flops before any edge detection on the pin.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      trig_s1_reg <= 1'b0;
      trig_s2_reg <= 1'b0;
      trig_d_reg <= 1'b0;
      sw_d_reg <= 1'b0;
    end else begin
      trig_s1_reg <= trigger_in;
      trig_s2_reg <= trig_s1_reg;
      trig_d_reg <= trig_s2_reg;
      sw_d_reg <= sw_trigger;
    end
  end

  assign trig_rise = trig_s2_reg && !trig_d_reg;
  assign trig_fall = !trig_s2_reg && trig_d_reg;
  assign sw_rise = sw_trigger && !sw_d_reg;

  // Area of interest shortens the frame to the chosen band of lines.
  assign lines_to_read = aoi_en ? aoi_lines : frame_lines;
  assign first_line = aoi_en ? aoi_first_line : '0;
  assign lv_fall = line_valid_strobe && (col_reg == line_cycles - 16'h0001);
  // The whole sequencer freezes while the output buffer is full.
  assign stall = !buf_in_ready;

  // Software trigger is latched so a pulse during readout is not lost.
  // It stays set through the exposure, because the count and not the pin ends that one.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sw_pending_reg <= 1'b0;
    end else if (sw_rise) begin
      sw_pending_reg <= 1'b1;
    end else if (state_reg == ETR_ST_DELAY) begin
      sw_pending_reg <= 1'b0;
    end
  end

  // Capture sequencer; counts are in whole clock periods of 15 ns.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= ETR_ST_IDLE;
      cnt_reg <= '0;
      exposing <= 1'b0;
      sync_line_wait_reg <= 1'b0;
    end else if (!stall) begin
      if (sync_line_wait_reg && lv_fall) begin
        sync_line_wait_reg <= 1'b0;
        exposing <= 1'b1;
      end
      // A hardware rise during readout waits for the next line end; a new rise wins.
      if (mode_trig && trig_rise && frame_valid_strobe) begin
        sync_line_wait_reg <= 1'b1;
      end
      case (state_reg)
        ETR_ST_IDLE: begin
          if (exposing) begin
            // An overlapped exposure is already running; follow it to its end.
            state_reg <= ETR_ST_EXPOSE;
            cnt_reg <= '0;
          end else if (run_en && !mode_trig) begin
            state_reg <= ETR_ST_EXPOSE;
            exposing <= 1'b1;
            cnt_reg <= '0;
          end else if (run_en && mode_trig && (trig_rise || sw_pending_reg)) begin
            state_reg <= ETR_ST_ARM;
            cnt_reg <= '0;
          end
        end
        ETR_ST_ARM: begin
          // Constant short delay with no line alignment.
          if (cnt_reg[7:0] >= ETR_START_DLY_CYC - 8'h01) begin
            state_reg <= ETR_ST_EXPOSE;
            exposing <= 1'b1;
            cnt_reg <= '0;
          end else begin
            cnt_reg <= cnt_reg + 24'h000001;
          end
        end
        ETR_ST_EXPOSE: begin
          cnt_reg <= cnt_reg + 24'h000001;
          // Triggered exposure ends with the pulse but starts after the arm delay or a line end.
          if (mode_trig && !sw_pending_reg && trig_fall) begin
            state_reg <= ETR_ST_DELAY;
            exposing <= 1'b0;
            cnt_reg <= '0;
          end else if ((!mode_trig || sw_pending_reg) &&
                       cnt_reg >= exposure_cycles - 24'h000001) begin
            state_reg <= ETR_ST_DELAY;
            exposing <= 1'b0;
            cnt_reg <= '0;
          end
        end
        ETR_ST_DELAY: begin
          if (cnt_reg >= readout_delay_cycles) begin
            state_reg <= ETR_ST_READ;
            cnt_reg <= '0;
          end else begin
            cnt_reg <= cnt_reg + 24'h000001;
          end
        end
        ETR_ST_READ: begin
          if (lv_fall && line_reg == first_line + lines_to_read - 16'h0001) begin
            state_reg <= ETR_ST_GAP;
            cnt_reg <= '0;
          end
        end
        ETR_ST_GAP: begin
          // Free run restarts right away for a continuous stream.
          state_reg <= ETR_ST_IDLE;
        end
        default: begin
          state_reg <= ETR_ST_IDLE;
        end
      endcase
    end
  end

  // Line and column timing; frame valid covers the whole readout.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      col_reg <= '0;
      line_reg <= '0;
      line_valid_strobe <= 1'b0;
      frame_valid_strobe <= 1'b0;
    end else if (!stall) begin
      if (state_reg == ETR_ST_DELAY && cnt_reg >= readout_delay_cycles) begin
        frame_valid_strobe <= 1'b1;
        line_valid_strobe <= 1'b1;
        col_reg <= '0;
        line_reg <= first_line;
      end else if (state_reg == ETR_ST_READ) begin
        if (lv_fall) begin
          line_valid_strobe <= 1'b0;
          col_reg <= '0;
          line_reg <= line_reg + 16'h0001;
          if (line_reg == first_line + lines_to_read - 16'h0001) begin
            frame_valid_strobe <= 1'b0;
          end
        end else if (!line_valid_strobe) begin
          // Short blank between lines keeps a visible line valid fall.
          if (col_reg >= ETR_LINE_GAP_CYC) begin
            line_valid_strobe <= 1'b1;
            col_reg <= '0;
          end else begin
            col_reg <= col_reg + 16'h0001;
          end
        end else begin
          col_reg <= col_reg + 16'h0001;
        end
      end else begin
        line_valid_strobe <= 1'b0;
        frame_valid_strobe <= 1'b0;
      end
    end
  end

  // Table and defect maps are written by software at any time.
  always_ff @(posedge core_clk) begin
    if (lut_wr_en) begin
      lut_mem[lut_wr_addr] <= lut_wr_data;
    end
    if (map_wr_en && map_wr_custom) begin
      map_custom[map_wr_addr] <= map_wr_data;
    end
    if (map_wr_en && !map_wr_custom) begin
      map_factory[map_wr_addr] <= map_wr_data;
    end
  end

  // Entries count only once written, so unwritten storage never flags a pixel.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      map_custom_vld_reg <= '0;
      map_factory_vld_reg <= '0;
    end else if (map_wr_en && map_wr_custom) begin
      map_custom_vld_reg[map_wr_addr] <= 1'b1;
    end else if (map_wr_en) begin
      map_factory_vld_reg[map_wr_addr] <= 1'b1;
    end
  end

  // Without the table the upper eight bits pass through.
  assign mapped_pix = lut_en ? lut_mem[sensor_pixel] : sensor_pixel[11:4];

  // Full map search per pixel: simple, but limits the map to 64 entries.
  always_comb begin
    defect_hit = 1'b0;
    for (int i = 0; i < ETR_MAP_DEPTH; i++) begin
      if (dpc_custom_sel) begin
        defect_hit = defect_hit |
          (map_custom_vld_reg[i] && map_match(map_custom[i], line_reg, col_reg));
      end else begin
        defect_hit = defect_hit |
          (map_factory_vld_reg[i] && map_match(map_factory[i], line_reg, col_reg));
      end
    end
  end

  // The first pixel of a line has no left neighbour, so it keeps its value.
  assign corr_pix = (dpc_en && defect_hit && col_reg != '0) ? prev_pix_reg : mapped_pix;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      prev_pix_reg <= '0;
    end else if (line_valid_strobe && !stall) begin
      prev_pix_reg <= corr_pix;
    end
  end

  assign buf_in_data = {line_valid_strobe, frame_valid_strobe, corr_pix};

  etr_skid_buf #(
    .W(ETR_PIX_OUT_W + 2)
  ) u_buf (
    .core_clk(core_clk),
    .rst(rst),
    .in_data(buf_in_data),
    .in_valid(line_valid_strobe),
    .in_ready(buf_in_ready),
    .out_data(buf_out_data),
    .out_valid(buf_out_valid),
    .out_ready(pix_ready)
  );

  // Registered pixel output; valid drops while the receiver stalls.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pix_data <= '0;
      pix_valid <= 1'b0;
      pix_line_valid <= 1'b0;
    end else begin
      pix_data <= buf_out_data[ETR_PIX_OUT_W-1:0];
      pix_valid <= buf_out_valid && pix_ready;
      pix_line_valid <= buf_out_valid && buf_out_data[ETR_PIX_OUT_W+1];
    end
  end

  // Temperature tracking and flashing red indicator.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      temp_value <= '0;
      temp_high <= 1'b0;
      blink_cnt_reg <= ETR_BLINK_HALF_CYC;
      red_led <= 1'b0;
    end else begin
      temp_value <= temp_sample;
      temp_high <= (temp_sample >= temp_limit);
      // The counter waits at its end while cool, so the indicator lights at once when hot.
      if (!temp_high) begin
        blink_cnt_reg <= ETR_BLINK_HALF_CYC;
        red_led <= 1'b0;
      end else if (blink_cnt_reg >= ETR_BLINK_HALF_CYC) begin
        blink_cnt_reg <= '0;
        red_led <= !red_led;
      end else begin
        blink_cnt_reg <= blink_cnt_reg + 24'h000001;
      end
    end
  end
endmodule : etr_ctrl

// ### etr_ctrl_monitor.sv
`timescale 1ns/10ps
// Port-level checker for the capture sequencer.
module etr_ctrl_monitor
  import etr_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic mode_trig,
  input wire logic run_en,
  input wire logic [ETR_DUR_W-1:0] exposure_cycles,
  input wire logic [ETR_DUR_W-1:0] readout_delay_cycles,
  input wire logic trigger_in,
  input wire logic [ETR_CNT_W-1:0] frame_lines,
  input wire logic aoi_en,
  input wire logic [ETR_CNT_W-1:0] aoi_lines,
  input wire logic [7:0] temp_sample,
  input wire logic [7:0] temp_limit,
  input wire logic exposing,
  input wire logic line_valid_strobe,
  input wire logic frame_valid_strobe,
  input wire logic temp_high,
  input wire logic red_led
);
  logic lv_reg;
  logic [ETR_DUR_W-1:0] exp_cnt_reg;
  logic [ETR_DUR_W-1:0] gap_cnt_reg;
  logic [ETR_CNT_W-1:0] ln_cnt_reg;
  logic [7:0] idle_cnt_reg;

  // Running counts; the idle count saturates so that it never wraps into a false idle.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      lv_reg <= 1'h0;
      exp_cnt_reg <= '0;
      gap_cnt_reg <= '0;
      ln_cnt_reg <= '0;
      idle_cnt_reg <= 8'h00;
    end else begin
      lv_reg <= line_valid_strobe;
      exp_cnt_reg <= exposing ? exp_cnt_reg + 1'b1 : '0;
      gap_cnt_reg <= exposing ? '0 : gap_cnt_reg + 1'b1;
      ln_cnt_reg <= !frame_valid_strobe ? '0 :
        ln_cnt_reg + ETR_CNT_W'(line_valid_strobe & ~lv_reg);
      idle_cnt_reg <= (exposing || frame_valid_strobe) ? 8'h00 :
        idle_cnt_reg + 8'(idle_cnt_reg != 8'hFF);
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  AST_LV_IN_FV: assert property (line_valid_strobe |-> frame_valid_strobe)
    else $error("Line strobe outside frame.");
  AST_LINES: assert property ($fell(frame_valid_strobe) |->
    ln_cnt_reg == (aoi_en ? aoi_lines : frame_lines))
    else $error("Wrong line count in frame.");
  AST_FREE_LEN: assert property ($fell(exposing) && !mode_trig |->
    exp_cnt_reg >= exposure_cycles && exp_cnt_reg <= exposure_cycles + 24'h000001)
    else $error("Free-run exposure length wrong.");
  AST_FREE_CONT: assert property ($fell(frame_valid_strobe) && !mode_trig && run_en
    |-> ##[1:60] exposing)
    else $error("Free run did not continue.");
  AST_RD_DLY: assert property ($rose(frame_valid_strobe) |->
    gap_cnt_reg >= readout_delay_cycles && gap_cnt_reg <= readout_delay_cycles + 24'h000004)
    else $error("Readout delay wrong.");
  AST_IDLE_START: assert property ($rose(trigger_in) && mode_trig && run_en
    && idle_cnt_reg == 8'hFF |-> (!exposing)[*8] ##[2:10] exposing)
    else $error("Idle trigger start delay wrong.");
  AST_FALL_END: assert property ($fell(trigger_in) && exposing && mode_trig
    |-> ##[1:6] !exposing)
    else $error("Exposure did not end on trigger fall.");
  AST_OVL_SYNC: assert property ($rose(exposing) && frame_valid_strobe |->
    !line_valid_strobe && (lv_reg || $past(lv_reg)))
    else $error("Overlapped exposure not on line fall.");
  AST_TEMP_HI: assert property ((temp_sample > temp_limit)[*3] |-> temp_high)
    else $error("High temperature not flagged.");
  AST_TEMP_LO: assert property ((temp_sample < temp_limit)[*3] |-> !temp_high)
    else $error("Temperature flag without cause.");
  AST_LED_OFF: assert property ((!temp_high)[*3] |-> !red_led)
    else $error("Red indicator lit while cool.");
  AST_LED_ON: assert property ($rose(temp_high) |=> red_led)
    else $error("Red indicator not lit when hot.");
endmodule : etr_ctrl_monitor

bind etr_ctrl etr_ctrl_monitor mon (
  .core_clk(core_clk), .rst(rst), .mode_trig(mode_trig), .run_en(run_en),
  .exposure_cycles(exposure_cycles), .readout_delay_cycles(readout_delay_cycles),
  .trigger_in(trigger_in), .frame_lines(frame_lines), .aoi_en(aoi_en),
  .aoi_lines(aoi_lines), .temp_sample(temp_sample), .temp_limit(temp_limit),
  .exposing(exposing), .line_valid_strobe(line_valid_strobe),
  .frame_valid_strobe(frame_valid_strobe), .temp_high(temp_high), .red_led(red_led)
);

// ### etr_trig_src.sv
`timescale 1ns/10ps
// External trigger source: a pulse of at least the asked width, held until readout ends.
module etr_trig_src (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic go,
  input wire logic [15:0] width,
  input wire logic frame_valid_strobe,
  output logic trigger_in
);
  logic [15:0] hold_reg;

  // A request is taken only while the line is low, so two pulses never merge.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      trigger_in <= 1'h0;
      hold_reg <= 16'h0000;
    end else if (go && !trigger_in) begin
      trigger_in <= 1'h1;
      hold_reg <= width;
    end else if (hold_reg != 16'h0000) begin
      hold_reg <= hold_reg - 16'h0001;
    end else if (!frame_valid_strobe) begin
      trigger_in <= 1'h0;
    end
  end
endmodule : etr_trig_src

// ### testbench.sv
`timescale 1ns/10ps
// Scenario bench for the capture controller.
module testbench
  import etr_pkg::*;
;
  logic core_clk, rst = 1'h1, go = 1'h0, stall = 1'h0, pix_ready = 1'h1;
  logic mode_trig = 1'h0, run_en = 1'h0, trigger_in, sw_trigger = 1'h0, aoi_en = 1'h0;
  logic lut_en = 1'h0, lut_wr_en = 1'h0, dpc_en = 1'h0, dpc_custom_sel = 1'h0;
  logic map_wr_en = 1'h0, map_wr_custom = 1'h0;
  logic [ETR_DUR_W-1:0] exposure_cycles = 24'h000014, readout_delay_cycles = 24'h000005;
  logic [ETR_CNT_W-1:0] line_cycles = 16'h0006, frame_lines = 16'h0004;
  logic [ETR_CNT_W-1:0] aoi_first_line = 16'h0001, aoi_lines = 16'h0002;
  logic [ETR_PIX_IN_W-1:0] sensor_pixel = 12'hABC, lut_wr_addr = 12'h000;
  logic [ETR_PIX_OUT_W-1:0] lut_wr_data = 8'h00, pix_data, last_pix;
  logic [ETR_MAP_AW-1:0] map_wr_addr = 6'h00;
  logic [31:0] map_wr_data = 32'h0;
  logic [7:0] temp_sample = 8'h20, temp_limit = 8'h50, temp_value;
  logic [15:0] width = 16'h0000;
  logic exposing, line_valid_strobe, frame_valid_strobe, pix_valid, pix_line_valid;
  logic temp_high, red_led, ex_q, fv_q, lv_q;
  int err_total, n_checks, cyc_n, ecnt, exp_len, dcnt, d_len, lines, pixs, ovl, plv_bad;

  etr_ctrl uut (
    .core_clk(core_clk), .rst(rst), .mode_trig(mode_trig), .run_en(run_en),
    .exposure_cycles(exposure_cycles), .readout_delay_cycles(readout_delay_cycles),
    .trigger_in(trigger_in), .sw_trigger(sw_trigger), .line_cycles(line_cycles),
    .frame_lines(frame_lines), .aoi_en(aoi_en), .aoi_first_line(aoi_first_line),
    .aoi_lines(aoi_lines), .sensor_pixel(sensor_pixel), .lut_en(lut_en),
    .lut_wr_en(lut_wr_en), .lut_wr_addr(lut_wr_addr), .lut_wr_data(lut_wr_data),
    .dpc_en(dpc_en), .dpc_custom_sel(dpc_custom_sel), .map_wr_en(map_wr_en),
    .map_wr_custom(map_wr_custom), .map_wr_addr(map_wr_addr), .map_wr_data(map_wr_data),
    .temp_sample(temp_sample), .temp_limit(temp_limit), .pix_ready(pix_ready),
    .exposing(exposing), .line_valid_strobe(line_valid_strobe),
    .frame_valid_strobe(frame_valid_strobe), .pix_data(pix_data), .pix_valid(pix_valid),
    .pix_line_valid(pix_line_valid), .temp_value(temp_value), .temp_high(temp_high),
    .red_led(red_led)
  );
  etr_trig_src src (
    .core_clk(core_clk), .rst(rst), .go(go), .width(width),
    .frame_valid_strobe(frame_valid_strobe), .trigger_in(trigger_in)
  );

  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end

  // Per-frame measurements; scenarios judge them after each frame.
  always @(posedge core_clk) begin
    ex_q <= exposing;
    fv_q <= frame_valid_strobe;
    lv_q <= line_valid_strobe;
    ecnt <= exposing ? ecnt + 1 : 0;
    if (ex_q && !exposing) exp_len <= ecnt;
    dcnt <= exposing ? 0 : dcnt + 1;
    if (frame_valid_strobe && !fv_q) d_len <= dcnt;
    lines <= (frame_valid_strobe && !fv_q ? 0 : lines) + int'(line_valid_strobe && !lv_q);
    pixs <= (frame_valid_strobe && !fv_q ? 0 : pixs) + int'(pix_valid);
    if (pix_valid) last_pix <= pix_data;
    if (pix_valid && !pix_line_valid) plv_bad <= plv_bad + 1;
    if (exposing && !ex_q && frame_valid_strobe) ovl <= 1;
    pix_ready <= #1 stall ? ~pix_ready : 1'h1;
  end

  // A hang ends the run here rather than stalling the simulator.
  always @(posedge core_clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      err_total++;
      complete_run();
    end
  end

  task tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task frame_end;
    @(negedge frame_valid_strobe);
    tick(12);
  endtask : frame_end

  task trig(input logic [15:0] w);
    width = w;
    go = 1'h1;
    tick(1);
    go = 1'h0;
    frame_end();
  endtask : trig

  task pulse_sw;
    sw_trigger = 1'h1;
    tick(1);
    sw_trigger = 1'h0;
    tick(1);
  endtask : pulse_sw

  task t_temp;
    temp_sample = 8'h60;
    tick(4);
    chk(temp_high, 1);
    chk(temp_value, 8'h60);
    chk(red_led, 1);
    temp_sample = 8'h40;
    tick(4);
    chk(temp_high, 0);
    chk(red_led, 0);
  endtask : t_temp

  // Two free-run frames with no trigger; the second is the last one enabled.
  task t_free;
    run_en = 1'h1;
    frame_end();
    chk(lines, 4);
    chk(pixs, 24);
    chk(last_pix, 8'hAB);
    chk(exp_len, exposure_cycles);
    @(posedge frame_valid_strobe);
    tick(1);
    run_en = 1'h0;
    frame_end();
    chk(exp_len, exposure_cycles);
    tick(260);
  endtask : t_free

  // Pulse width sets exposure; raising the readout delay setting by 20 adds exactly 20 cycles.
  task t_trig;
    int e1;
    int d1;
    mode_trig = 1'h1;
    aoi_en = 1'h1;
    run_en = 1'h1;
    trig(16'd40);
    e1 = exp_len;
    d1 = d_len;
    chk(lines, 2);
    chk(pixs, 12);
    tick(260);
    readout_delay_cycles = 24'h000019;
    trig(16'd70);
    chk(exp_len - e1, 30);
    chk(d_len - d1, 20);
    readout_delay_cycles = 24'h000005;
    tick(260);
  endtask : t_trig

  task t_sw;
    pulse_sw();
    frame_end();
    chk(exp_len, exposure_cycles);
    tick(260);
  endtask : t_sw

  // Table and defect map in use while the receiver stalls every other cycle.
  task t_lut;
    lut_wr_addr = 12'hABC;
    lut_wr_data = 8'h5A;
    lut_wr_en = 1'h1;
    map_wr_en = 1'h1;
    map_wr_custom = 1'h1;
    map_wr_data = 32'h80010003;
    tick(1);
    lut_wr_en = 1'h0;
    map_wr_en = 1'h0;
    lut_en = 1'h1;
    dpc_en = 1'h1;
    dpc_custom_sel = 1'h1;
    pulse_sw();
    @(posedge frame_valid_strobe);
    stall = 1'h1;
    frame_end();
    stall = 1'h0;
    chk(pixs, 12);
    chk(last_pix, 8'h5A);
    tick(260);
  endtask : t_lut

  // Second trigger rises during readout of the first frame; full frames leave inner lines.
  task t_ovl;
    ovl = 0;
    aoi_en = 1'h0;
    width = 16'd10;
    go = 1'h1;
    tick(1);
    go = 1'h0;
    @(posedge frame_valid_strobe);
    tick(2);
    go = 1'h1;
    tick(1);
    go = 1'h0;
    frame_end();
    frame_end();
    chk(ovl, 1);
    chk(lines, 4);
    chk(plv_bad, 0);
  endtask : t_ovl

  task complete_run;
    $display("Checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run

  initial begin
    tick(20);
    rst = 1'h0;
    t_temp();
    t_free();
    t_trig();
    t_sw();
    t_lut();
    t_ovl();
    complete_run();
  end
endmodule : testbench
